// ===== verilog/ddc_pkg.sv
/*
  ddc_pkg: register map, field layout, timing counts and carrier structs
  for the drive control-cable interface. Assumes a 25 MHz clock.
*/
package ddc_pkg;
  localparam logic [3:0] OFF_CTRL   = 4'h0;
  localparam logic [3:0] OFF_STEP   = 4'h4;
  localparam logic [3:0] OFF_XFER   = 4'h8;
  localparam logic [3:0] OFF_STATUS = 4'hC;
  localparam int CTRL_UNIT  = 0;
  localparam int CTRL_WG    = 2;
  localparam int CTRL_RG    = 3;
  localparam int CTRL_AME   = 4;
  localparam int CTRL_DIR   = 5;
  localparam int CTRL_SAFE  = 6;
  localparam int CTRL_USTB  = 7;
  localparam int XFER_DATA  = 0;
  localparam int XFER_ADDR  = 8;
  localparam int XFER_KIND  = 10;
  localparam int XFER_GO    = 12;
  localparam logic [1:0] KIND_CMD  = 2'h0;
  localparam logic [1:0] KIND_ARG  = 2'h1;
  localparam logic [1:0] KIND_STAT = 2'h2;
  localparam int CLK_MHZ       = 25;
  localparam int STEP_PULSE_NS = 1000;
  localparam int STEP_GAP_NS   = 3000;
  localparam int USTB_NS       = 1000;
  localparam int DIR_SETUP_NS  = 1000;
  localparam int STEP_PULSE_CYC = (STEP_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int STEP_GAP_CYC   = (STEP_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int USTB_CYC       = (USTB_NS * CLK_MHZ + 999) / 1000;
  localparam int DIR_SETUP_CYC  = (DIR_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  typedef enum logic [1:0]
  {
    ST_IDLE,
    ST_DRIVE,
    ST_WAIT,
    ST_RELEASE
  } ddc_bus_t;
  typedef struct packed {
    logic [3:0] unit_select_n;
    logic [3:0] head_select_n;
    logic       write_gate_n;
    logic       read_gate_n;
    logic       address_mark_n;
    logic       dir_n;
    logic       step_n;
    logic       command_n;
    logic [1:0] reg_address_n;
  } ddc_ctl_t;
  typedef struct packed {
    logic index_n;
    logic sector_n;
    logic fault_n;
    logic seek_done_n;
    logic ready_n;
    logic busy_n;
    logic attention_n;
    logic ack;
  } ddc_stat_t;
endpackage

// ===== verilog/ddc_stepper.sv
/*
  ddc_stepper: emits a counted burst of active-low step pulses after a
  direction setup time. Assumes the direction level is held by the caller.
*/
module ddc_stepper (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       start,
  input  wire logic [7:0] count,
  output logic            step_n,
  output logic            busy
);
  typedef struct packed {
    logic [7:0]  left;
    logic [7:0]  timer;
    logic [1:0]  phase;
    logic        step_n;
  } ddc_step_t;
  ddc_step_t s_reg;
  ddc_step_t s_next;
  always_comb
  begin
    s_next = s_reg;
    if (s_reg.phase == 2'h0)
    begin
      if (start && count != 8'h00)
      begin
        s_next.left  = count;
        s_next.timer = 8'(ddc_pkg::DIR_SETUP_CYC - 1);
        s_next.phase = 2'h1;
      end
    end
    else if (s_reg.timer != 8'h00)
      s_next.timer = s_reg.timer - 8'h01;
    else if (s_reg.phase == 2'h1)
    begin
      s_next.step_n = 1'b0;
      s_next.timer  = 8'(ddc_pkg::STEP_PULSE_CYC - 1);
      s_next.phase  = 2'h2;
    end
    else if (s_reg.phase == 2'h2)
    begin
      s_next.step_n = 1'b1;
      s_next.left   = s_reg.left - 8'h01;
      s_next.timer  = 8'(ddc_pkg::STEP_GAP_CYC - 1);
      s_next.phase  = 2'h3;
    end
    else
    begin
      // gap keeps pulses from merging at the drive
      s_next.phase = (s_reg.left == 8'h00) ? 2'h0 : 2'h1;
      s_next.timer = 8'h00;
    end
  end
  always_ff @(posedge clk)
  begin
    if (reset)
      s_reg <= '{left: 8'h00, timer: 8'h00, phase: 2'h0, step_n: 1'b1};
    else
      s_reg <= s_next;
  end
  assign step_n = s_reg.step_n;
  assign busy   = s_reg.phase != 2'h0;
endmodule

// ===== verilog/ddc_ctrl.sv
/*
  ddc_ctrl: controller side of the drive control cable with an Avalon-MM
  slave. Assumes drive inputs are synchronous to clk and the bus is
  resolved outside from the output enable.
*/
module ddc_ctrl (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [3:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              power_good,
  output ddc_pkg::ddc_ctl_t      ctl,
  input  wire ddc_pkg::ddc_stat_t stat,
  input  wire logic [7:0]        drive_parallel_in,
  output logic [7:0]             drive_parallel_out,
  output logic                   drive_parallel_oe
);
  typedef struct packed {
    logic [7:0]        ctrl;
    logic [7:0]        steps;
    logic [7:0]        data;
    logic [1:0]        addr;
    logic [1:0]        kind;
    logic [7:0]        rdata;
    logic              done;
    ddc_pkg::ddc_bus_t state;
    logic [7:0]        ustb_timer;
    logic              ustb;
    logic              step_go;
    logic              bus_oe;
    logic              cmd;
    logic              arg;
    logic [31:0]       readdata;
    logic              ack;
    logic              index_seen;
    logic              sector_seen;
  } ddc_state_t;
  ddc_state_t r_reg;
  ddc_state_t r_next;
  logic       stepper_step_n;
  logic       stepper_busy;
  logic       xfer_busy;
  function automatic logic [3:0] unit_decode(input logic [1:0] u);
    unit_decode = ~(4'h1 << u);
  endfunction
  ddc_stepper u_step (
    .clk    (clk),
    .reset  (reset),
    .start  (r_reg.step_go),
    .count  (r_reg.steps),
    .step_n (stepper_step_n),
    .busy   (stepper_busy)
  );
  assign xfer_busy = r_reg.state != ddc_pkg::ST_IDLE;
  always_comb
  begin
    r_next = r_reg;
    r_next.step_go = 1'b0;
    r_next.ack = 1'b0;
    if (!stat.index_n)
      r_next.index_seen = 1'b1;
    if (!stat.sector_n)
      r_next.sector_seen = 1'b1;
    // countdown first so a fresh strobe write below wins
    if (r_reg.ustb)
    begin
      if (r_reg.ustb_timer == 8'h00)
        r_next.ustb = 1'b0;
      else
        r_next.ustb_timer = r_reg.ustb_timer - 8'h01;
    end
    if ((avs_read || avs_write) && !r_reg.ack)
    begin
      r_next.ack = 1'b1;
      r_next.readdata = 32'h0000_0000;
      if (avs_address == ddc_pkg::OFF_CTRL)
      begin
        r_next.readdata[7:0] = r_reg.ctrl;
        if (avs_write)
        begin
          r_next.ctrl = avs_writedata[7:0];
          // direction frozen during a burst
          if (stepper_busy)
            r_next.ctrl[ddc_pkg::CTRL_DIR] = r_reg.ctrl[ddc_pkg::CTRL_DIR];
          if (avs_writedata[ddc_pkg::CTRL_USTB])
          begin
            r_next.ustb = 1'b1;
            r_next.ustb_timer = 8'(ddc_pkg::USTB_CYC - 1);
          end
        end
      end
      else if (avs_address == ddc_pkg::OFF_STEP)
      begin
        r_next.readdata[7:0] = r_reg.steps;
        r_next.readdata[8] = stepper_busy;
        if (avs_write && !stepper_busy)
        begin
          r_next.steps = avs_writedata[7:0];
          r_next.step_go = 1'b1;
        end
      end
      else if (avs_address == ddc_pkg::OFF_XFER)
      begin
        r_next.readdata[7:0] = r_reg.rdata;
        r_next.readdata[9:8] = r_reg.addr;
        r_next.readdata[11:10] = r_reg.kind;
        r_next.readdata[12] = xfer_busy;
        r_next.readdata[13] = r_reg.done;
        if (avs_write && !xfer_busy
            && avs_writedata[ddc_pkg::XFER_GO])
        begin
          r_next.data = avs_writedata[7:0];
          r_next.addr = avs_writedata[9:8];
          r_next.kind = avs_writedata[11:10];
          r_next.done = 1'b0;
          r_next.state = ddc_pkg::ST_DRIVE;
        end
        else if (avs_read)
          r_next.done = 1'b0;
      end
      else if (avs_address == ddc_pkg::OFF_STATUS)
      begin
        r_next.readdata[0] = r_reg.index_seen;
        r_next.readdata[1] = r_reg.sector_seen;
        r_next.readdata[2] = ~stat.fault_n;
        r_next.readdata[3] = ~stat.seek_done_n;
        r_next.readdata[4] = ~stat.ready_n;
        r_next.readdata[5] = ~stat.busy_n;
        r_next.readdata[6] = ~stat.attention_n;
        // set wins: clear only where no new edge this cycle
        if (avs_write && avs_writedata[0] && stat.index_n)
          r_next.index_seen = 1'b0;
        if (avs_write && avs_writedata[1] && stat.sector_n)
          r_next.sector_seen = 1'b0;
      end
    end
    case (r_reg.state)
      ddc_pkg::ST_DRIVE:
      begin
        // data and address settle a cycle ahead of the strobe
        r_next.bus_oe = r_reg.kind != ddc_pkg::KIND_STAT;
        r_next.state = ddc_pkg::ST_WAIT;
      end
      ddc_pkg::ST_WAIT:
      begin
        r_next.cmd = r_reg.kind == ddc_pkg::KIND_CMD;
        r_next.arg = r_reg.kind == ddc_pkg::KIND_ARG;
        // status waits for the drive's request before reading
        if (stat.ack && (r_reg.kind != ddc_pkg::KIND_STAT
            || !stat.attention_n))
        begin
          if (r_reg.kind == ddc_pkg::KIND_STAT)
            r_next.rdata = ~drive_parallel_in;
          r_next.cmd = 1'b0;
          r_next.arg = 1'b0;
          r_next.state = ddc_pkg::ST_RELEASE;
        end
      end
      ddc_pkg::ST_RELEASE:
      begin
        // no new cycle until the drive drops its acknowledge
        r_next.bus_oe = 1'b0;
        if (!stat.ack)
        begin
          r_next.done = 1'b1;
          r_next.state = ddc_pkg::ST_IDLE;
        end
      end
      default:
      begin
        r_next.cmd = 1'b0;
        r_next.arg = 1'b0;
      end
    endcase
  end
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      r_reg <= '0;
      r_reg.ctrl <= ddc_pkg::CTRL_RESET;
      r_reg.state <= ddc_pkg::ST_IDLE;
    end
    else
      r_reg <= r_next;
  end
  assign avs_waitrequest = (avs_read || avs_write) && !r_reg.ack;
  assign avs_readdata = r_reg.readdata;
  always_comb
  begin
    ctl.unit_select_n = unit_decode(r_reg.ctrl[1:0]);
    ctl.head_select_n[0] = 1'b1;
    ctl.head_select_n[1] = ~(r_reg.ctrl[ddc_pkg::CTRL_SAFE]
                             && power_good);
    ctl.head_select_n[2] = ~r_reg.ustb;
    ctl.head_select_n[3] = ~r_reg.arg;
    ctl.write_gate_n = ~r_reg.ctrl[ddc_pkg::CTRL_WG];
    ctl.read_gate_n = ~r_reg.ctrl[ddc_pkg::CTRL_RG];
    // mark only meaningful beside a gate
    ctl.address_mark_n = ~(r_reg.ctrl[ddc_pkg::CTRL_AME]
      && (r_reg.ctrl[ddc_pkg::CTRL_WG] || r_reg.ctrl[ddc_pkg::CTRL_RG]));
    ctl.dir_n = r_reg.ctrl[ddc_pkg::CTRL_DIR];
    ctl.step_n = stepper_step_n;
    ctl.command_n = ~r_reg.cmd;
    ctl.reg_address_n = ~r_reg.addr;
  end
  assign drive_parallel_out = ~r_reg.data;
  assign drive_parallel_oe = r_reg.bus_oe;
endmodule

// ===== sim/ddc_ctrl_chk.sv
/*
  ddc_ctrl_chk: port assertions for the cable controller.
  assumes it is bound into every ddc_ctrl instance.
*/
module ddc_ctrl_chk (
  input wire logic               clk,
  input wire logic               reset,
  input wire logic               power_good,
  input wire ddc_pkg::ddc_ctl_t  ctl,
  input wire ddc_pkg::ddc_stat_t stat,
  input wire logic [7:0]         drive_parallel_out,
  input wire logic               drive_parallel_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // step low time counter; wraps only if stuck low
  logic [5:0] low_reg;
  always_ff @(posedge clk)
    low_reg <= ctl.step_n ? 6'h00 : low_reg + 6'h01;
  sequence s_step_end;
    $rose(ctl.step_n);
  endsequence
  sequence s_cmd_wait;
    !ctl.command_n && !stat.ack;
  endsequence
  property p_one_unit;
    $onehot(~ctl.unit_select_n);
  endproperty
  a_one_unit: assert property (p_one_unit) else $error("unit select");
  property p_hs0;
    ctl.head_select_n[0];
  endproperty
  a_hs0: assert property (p_hs0) else $error("head line 0 used");
  property p_safe;
    !ctl.head_select_n[1] |-> power_good;
  endproperty
  a_safe: assert property (p_safe) else $error("safe without power");
  property p_ame;
    !ctl.address_mark_n |-> !ctl.write_gate_n || !ctl.read_gate_n;
  endproperty
  a_ame: assert property (p_ame) else $error("mark enable alone");
  property p_step;
    s_step_end |-> low_reg == 6'h19;
  endproperty
  a_step: assert property (p_step) else $error("step width");
  property p_dir;
    !ctl.step_n |-> $stable(ctl.dir_n);
  endproperty
  a_dir: assert property (p_dir) else $error("direction moved");
  property p_cmd_oe;
    !ctl.command_n |-> drive_parallel_oe;
  endproperty
  a_cmd_oe: assert property (p_cmd_oe) else $error("command no data");
  property p_arg_oe;
    !ctl.head_select_n[3] |-> drive_parallel_oe;
  endproperty
  a_arg_oe: assert property (p_arg_oe) else $error("arg no data");
  property p_hold;
    s_cmd_wait |=> !ctl.command_n && $stable(drive_parallel_out)
      && $stable(ctl.reg_address_n);
  endproperty
  a_hold: assert property (p_hold) else $error("cycle not held");
  property p_ack;
    !ctl.command_n && stat.ack |-> ##[1:3] ctl.command_n;
  endproperty
  a_ack: assert property (p_ack) else $error("strobe kept");
  property p_ustb;
    $fell(ctl.head_select_n[2]) |=> !ctl.head_select_n[2] [*8];
  endproperty
  a_ustb: assert property (p_ustb) else $error("unit strobe short");
endmodule

bind ddc_ctrl ddc_ctrl_chk u_chk (
  .clk(clk), .reset(reset), .power_good(power_good), .ctl(ctl),
  .stat(stat), .drive_parallel_out(drive_parallel_out),
  .drive_parallel_oe(drive_parallel_oe)
);

// ===== sim/ddc_drive_model.sv
/*
  ddc_drive_model: one behavioural drive on the control cable.
  assumes the bench resolves the shared bus with a pull-up.
*/
module ddc_drive_model (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire ddc_pkg::ddc_ctl_t ctl,
  input  wire logic [7:0]        bus,
  input  wire logic              son,
  input  wire logic [7:0]        sbyte,
  input  wire logic              flt,
  input  wire logic [3:0]        dly,
  output ddc_pkg::ddc_stat_t     stat,
  output logic                   moe,
  output logic [7:0]             mdata,
  output logic [7:0]             gbyte,
  output logic [1:0]             gaddr,
  output logic                   garg
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       req;
  logic       ack;
  logic [5:0] rev;
  int         cnt;
  assign req   = !ctl.command_n || !ctl.head_select_n[3] || son;
  assign moe   = son;
  assign mdata = ~sbyte;
  assign stat  = '{index_n: rev != 6'h00,
                   sector_n: rev != 6'h20,
                   fault_n: !flt,
                   seek_done_n: !ctl.step_n,
                   ready_n: 1'b0,
                   busy_n: !req,
                   attention_n: !son,
                   ack: ack};
  always @(posedge clk)
  begin
    rev <= reset ? 6'h00 : rev + 6'h01;
    if (reset || !req)
    begin
      cnt <= 0;
      ack <= 1'b0;
    end
    else
    begin
      cnt <= cnt + 1;
      // slow or prompt answer, ack dropped after four cycles
      ack <= cnt >= dly && cnt < dly + 4;
      if (cnt == dly)
      begin
        gbyte <= ~bus;
        gaddr <= ~ctl.reg_address_n;
        garg  <= !ctl.head_select_n[3];
      end
    end
  end
endmodule

// ===== sim/ddc_ctrl_tb.sv
/*
  ddc_ctrl_tb: random and corner tests of the cable controller.
  assumes the drive model and the bound checker.
*/
module ddc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clk = 1'b0;
  logic               reset = 1'b1;
  logic [3:0]         adr;
  logic               rd;
  logic               wr;
  logic [31:0]        wd;
  logic [31:0]        rq;
  logic               wreq;
  logic               pg;
  ddc_pkg::ddc_ctl_t  ctl;
  ddc_pkg::ddc_stat_t stat;
  logic [7:0]         pin;
  logic [7:0]         pout;
  logic               poe;
  logic               son;
  logic               flt;
  logic [7:0]         sbyte;
  logic [7:0]         mdata;
  logic [7:0]         gbyte;
  logic [1:0]         gaddr;
  logic [3:0]         dly;
  logic               moe;
  logic               garg;
  logic [31:0]        q;
  logic [31:0]        v;
  int                 n_fail = 0;
  int                 tests_run = 0;
  int                 cyc = 0;
  int                 nsteps = 0;
  always #20 clk = ~clk;
  // pulled-up bus: released lines read as all ones
  assign pin = poe ? pout : (moe ? mdata : 8'hFF);
  ddc_ctrl dut (.clk(clk), .reset(reset), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_readdata(rq),
    .avs_waitrequest(wreq), .power_good(pg), .ctl(ctl), .stat(stat),
    .drive_parallel_in(pin), .drive_parallel_out(pout),
    .drive_parallel_oe(poe));
  ddc_drive_model drv (.clk(clk), .reset(reset), .ctl(ctl), .bus(pin),
    .son(son), .sbyte(sbyte), .flt(flt), .dly(dly), .stat(stat),
    .moe(moe), .mdata(mdata), .gbyte(gbyte), .gaddr(gaddr), .garg(garg));
  always @(negedge ctl.step_n) nsteps++;
  function automatic logic [3:0] exp_sel(input logic [1:0] u);
    return ~(4'h1 << u);
  endfunction
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic acc(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wr  <= w;
    rd  <= !w;
    wd  <= d;
    @(posedge clk);
    while (wreq !== 1'b0) @(posedge clk);
    q = rq;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic xfer_wait;
    q = 32'h1000;
    while (q[12]) acc(1'b0, ddc_pkg::OFF_XFER, 32'h0);
  endtask
  task end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      end_of_test;
    end
  end
  initial
  begin
    {adr, rd, wr, wd, son, flt, sbyte, dly} = '0;
    pg = 1'b1;
    void'($urandom(8));
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    #1 chk("sel_rst", ctl.unit_select_n, 4'hE);
    chk("hs0", ctl.head_select_n[0], 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      v = $urandom & 32'h7F;
      if (i < 4) v[1:0] = i[1:0];
      acc(1'b1, ddc_pkg::OFF_CTRL, v);
      pg <= $urandom;
      acc(1'b0, ddc_pkg::OFF_CTRL, 32'h0);
      #1 chk("ctrl", q[7:0], v[7:0]);
      chk("sel", ctl.unit_select_n, exp_sel(v[1:0]));
      chk("wg", ctl.write_gate_n, !v[2]);
      chk("rg", ctl.read_gate_n, !v[3]);
      chk("ame", ctl.address_mark_n, !(v[4] && (v[2] || v[3])));
      chk("safe", ctl.head_select_n[1], !(v[6] && pg));
      chk("dir", ctl.dir_n, v[5]);
    end
    acc(1'b1, ddc_pkg::OFF_CTRL, 32'h80);
    repeat (3) @(posedge clk);
    #1 chk("ustb", ctl.head_select_n[2], 1'b0);
    acc(1'b1, ddc_pkg::OFF_CTRL, 32'h20);
    nsteps = 0;
    v = 1 + $urandom % 3;
    acc(1'b1, ddc_pkg::OFF_STEP, v);
    acc(1'b1, ddc_pkg::OFF_STEP, 32'h5);
    q = 32'h100;
    while (q[8]) acc(1'b0, ddc_pkg::OFF_STEP, 32'h0);
    chk("steps", nsteps, v);
    for (int k = 0; k < 4; k++)
    begin
      dly <= $urandom % 6;
      v = $urandom & 32'h3FF;
      v[11:10] = k[0] ? ddc_pkg::KIND_ARG : ddc_pkg::KIND_CMD;
      v[12] = 1'b1;
      acc(1'b1, ddc_pkg::OFF_XFER, v);
      xfer_wait;
      chk("done", q[13], 1'b1);
      chk("byte", gbyte, v[7:0]);
      chk("addr", gaddr, v[9:8]);
      chk("kind", garg, v[10]);
    end
    sbyte <= $urandom;
    son <= 1'b1;
    acc(1'b1, ddc_pkg::OFF_XFER, 32'h1800);
    xfer_wait;
    son <= 1'b0;
    chk("status", q[7:0], sbyte);
    flt <= 1'b1;
    acc(1'b0, ddc_pkg::OFF_STATUS, 32'h0);
    chk("fault", q[2], 1'b1);
    chk("index", q[0], 1'b1);
    chk("sector", q[1], 1'b1);
    chk("seek", q[3], 1'b1);
    chk("ready", q[4], 1'b1);
    chk("busy", q[5], 1'b0);
    chk("attention_request", q[6], 1'b0);
    // clear right after an index pulse, well before the next one
    @(negedge stat.index_n);
    acc(1'b1, ddc_pkg::OFF_STATUS, 32'h3);
    acc(1'b0, ddc_pkg::OFF_STATUS, 32'h0);
    chk("clear", q[1:0], 2'h0);
    acc(1'b0, 4'h2, 32'h0);
    chk("unmapped", q, 32'h0);
    end_of_test;
  end
endmodule
